//--- tb.sv
`timescale 1ns/10ps
// bench for the suspend / resume sequencer with shortened counts
module tb;
  localparam int unsigned OSC_N = 8;  // shortened oscillator allowance
  localparam int unsigned DRV_N = 16; // shortened upstream resume
  logic ref_clk, rst, ce, slp_en, slp_mode, slp_exec, pin_en, susp_det, host_res;
  logic irq0, irq1, wake_n, clr_gs, clr_rs, clr_rw, osc_en, drv, susp, gs_f, rs_f, rw_f, irq;
  int   fails, total_checks, n;
  // rows: ext0, ext1, pin enable, pin level, wake expected
  logic [4:0] rows [5] = '{5'h13, 5'h0B, 5'h05, 5'h00, 5'h06};
  usr_suspend_resume #(.OSC_START_CYCLES(OSC_N), .RESUME_DRIVE_CYCLES(DRV_N)) dut_u (
    .REF_CLK(ref_clk), .RST(rst), .CE(ce), .SLEEP_ENABLE(slp_en), .SLEEP_MODE(slp_mode),
    .SLEEP_EXEC(slp_exec), .PIN_WAKE_EN(pin_en), .SUSPEND_DETECT(susp_det),
    .HOST_RESUME(host_res), .EXT_IRQ0(irq0), .EXT_IRQ1(irq1), .WAKE_PIN_N(wake_n),
    .CLR_GLOBAL_SUSPEND(clr_gs), .CLR_RESUME(clr_rs), .CLR_REMOTE_WAKEUP(clr_rw),
    .OSC_ENABLE(osc_en), .RESUME_DRIVE(drv), .SUSPENDED(susp), .GLOBAL_SUSPEND_FLAG(gs_f),
    .RESUME_FLAG(rs_f), .REMOTE_WAKEUP_FLAG(rw_f), .IRQ(irq));
  usr_host_model host_u (.clk(ref_clk), .resume_drive(drv), .host_resume(host_res));
  initial ref_clk = 1'h0;
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // gpio parking before sleep is firmware work outside this block
  // one sleep instruction pulse, then the suspend state is checked
  task automatic go_sleep(input logic exp);
    slp_exec = 1'h1;
    @(negedge ref_clk);
    slp_exec = 1'h0;
    chk("suspended", exp, susp);
    chk("osc_enable", !exp, osc_en);
  endtask
  // bounded wait for the resume flag, counting falling edges
  task automatic wait_flag(input int exp_n);
    n = 0;
    while (rs_f !== 1'h1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk("flag delay", 1'h1, n == exp_n);
    chk("irq", 1'h1, irq);
  endtask
  // pin and peripheral restore is firmware work outside this block
  task automatic clear_all();
    clr_gs = 1'h1;
    clr_rs = 1'h1;
    clr_rw = 1'h1;
    @(negedge ref_clk);
    {clr_gs, clr_rs, clr_rw} = 3'h0;
    pin_en = 1'h0;
    chk("irq cleared", 1'h0, irq);
  endtask
  // watchdog: the tests take well under 1000 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial begin
    {rst, ce, wake_n} = 3'h7;
    {slp_en, slp_mode, slp_exec, pin_en, susp_det, irq0, irq1, clr_gs, clr_rs, clr_rw} = '0;
    fails = 0;
    total_checks = 0;
    repeat (8) @(negedge ref_clk);
    rst = 1'h0;
    chk("osc after reset", 1'h1, osc_en);
    chk("outputs after reset", 1'h0, irq | susp | drv);
    slp_en = 1'h1;
    go_sleep(1'h0);
    slp_mode = 1'h1;
    susp_det = 1'h1;
    @(negedge ref_clk);
    susp_det = 1'h0;
    chk("global flag", 1'h1, gs_f & irq);
    clear_all();
    for (int i = 0; i < 5; i++) begin
      pin_en = rows[i][2];
      go_sleep(1'h1);
      {irq0, irq1, wake_n} = {rows[i][4:3], rows[i][1]};
      @(negedge ref_clk);
      {irq0, irq1, wake_n} = 3'h1;
      chk("resume drive", rows[i][0], drv);
      if (rows[i][0]) begin
        @(negedge ref_clk);
      end else begin
        host_u.send_resume(1);
      end
      chk("osc restarted", 1'h1, osc_en);
      wait_flag(OSC_N + 2);
      chk("remote flag", rows[i][0], rw_f);
      clr_rs = 1'h1;
      @(negedge ref_clk);
      clr_rs = 1'h0;
      chk("resume flag cleared", 1'h0, rs_f);
      chk("remote flag held", rows[i][0], rw_f);
      n = 0;
      while (drv === 1'h1 && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      @(negedge ref_clk);
      if (rows[i][0]) begin
        chk("drive length", 1'h1, host_u.drive_len inside {[DRV_N:DRV_N + 2]});
      end
      clear_all();
    end
    // frozen sequencer ignores the host; then host beats a local wake
    go_sleep(1'h1);
    ce = 1'h0;
    host_u.send_resume(1);
    chk("frozen", 1'h1, susp);
    ce = 1'h1;
    irq0 = 1'h1;
    host_u.send_resume(1);
    irq0 = 1'h0;
    chk("host wins", 1'h0, drv);
    wait_flag(OSC_N + 2);
    chk("no remote flag", 1'h0, rw_f);
    clear_all();
    conclude();
  end
endmodule

//--- usr_host_model.sv
`timescale 1ns/10ps
// usb host: signals resume on command and times the upstream resume
module usr_host_model (
  input  wire logic clk,          // reference clock
  input  wire logic resume_drive, // device drives resume upstream
  output logic      host_resume   // resume signaling toward the device
);
  int unsigned drive_len; // length of the last upstream resume
  int unsigned run_cnt;   // cycles of the drive in progress
  initial begin
    host_resume = 1'h0;
    drive_len   = 0;
    run_cnt     = 0;
  end
  // latch the length once the drive ends, so a short drive is visible
  always @(posedge clk) begin
    if (resume_drive) begin
      run_cnt <= run_cnt + 1;
    end else if (run_cnt != 0) begin
      drive_len <= run_cnt;
      run_cnt   <= 0;
    end
  end
  // called at a falling edge; holds resume for the given cycles
  task automatic send_resume(input int unsigned cycles);
    host_resume = 1'h1;
    repeat (cycles) @(negedge clk);
    host_resume = 1'h0;
  endtask
endmodule

//--- usr_pkg.sv
package usr_pkg;

  // reference clock rate, in MHz
  localparam int unsigned REF_CLK_MHZ     = 40;
  // oscillator start-up allowance, in microseconds
  localparam int unsigned OSC_START_US    = 2000;
  // length of upstream resume drive, in microseconds
  localparam int unsigned RESUME_DRIVE_US = 10000;
  // derived cycle counts; both are least times and divide exactly
  localparam int unsigned OSC_START_CYC    = OSC_START_US * REF_CLK_MHZ;
  localparam int unsigned RESUME_DRIVE_CYC = RESUME_DRIVE_US * REF_CLK_MHZ;
  // timer width that holds the largest count
  localparam int unsigned TIMER_W          = 20;

  // reset values of the control and flag state
  localparam logic        OSC_EN_RST = 1'b1;
  localparam logic        FLAG_RST   = 1'b0;

  // sequencer states, gray along awake, suspend, wake drive, restart, awake
  typedef enum logic [1:0] {
    ST_AWAKE    = 2'h0,
    ST_SUSPEND  = 2'h1,
    ST_WAKE_DRV = 2'h3,
    ST_RESTART  = 2'h2
  } usr_state_t;

endpackage

//--- usr_sr_assertions.sv
`timescale 1ns/10ps
// sequencer port checks; a side counter times the oscillator allowance
module usr_sr_assertions #(
  parameter int unsigned OSC_START_CYCLES    = 8,
  parameter int unsigned RESUME_DRIVE_CYCLES = 16
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic SLEEP_ENABLE,
  input wire logic SLEEP_MODE,
  input wire logic SLEEP_EXEC,
  input wire logic PIN_WAKE_EN,
  input wire logic HOST_RESUME,
  input wire logic EXT_IRQ0,
  input wire logic EXT_IRQ1,
  input wire logic WAKE_PIN_N,
  input wire logic CLR_RESUME,
  input wire logic CLR_REMOTE_WAKEUP,
  input wire logic OSC_ENABLE,
  input wire logic RESUME_DRIVE,
  input wire logic SUSPENDED,
  input wire logic RESUME_FLAG,
  input wire logic REMOTE_WAKEUP_FLAG,
  input wire logic IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire logic  sleep_req = CE && SLEEP_EXEC && SLEEP_ENABLE && SLEEP_MODE; // full request
  wire logic  wake_src  = EXT_IRQ0 || EXT_IRQ1 || (PIN_WAKE_EN && !WAKE_PIN_N); // local
  int unsigned osc_cnt_r; // cycles the oscillator has run
  int unsigned drv_cnt_r; // cycles the upstream drive has lasted
  // gated by ce so a frozen sequencer does not skew the count
  always_ff @(posedge REF_CLK) begin
    if (RST || !OSC_ENABLE) begin
      osc_cnt_r <= 0;
    end else if (CE) begin
      osc_cnt_r <= osc_cnt_r + 1;
    end
  end
  // drive length, frozen with the sequencer while ce is low
  always_ff @(posedge REF_CLK) begin
    if (RST || !RESUME_DRIVE) begin
      drv_cnt_r <= 0;
    end else if (CE) begin
      drv_cnt_r <= drv_cnt_r + 1;
    end
  end
  osc_stop_a: assert property ($fell(OSC_ENABLE) |-> $past(sleep_req) && SUSPENDED)
    else $error("oscillator stopped without a sleep request");
  host_resume_a: assert property (CE && SUSPENDED && HOST_RESUME |=>
    OSC_ENABLE && !SUSPENDED && !RESUME_DRIVE) else $error("host resume not taken");
  flag_delay_a: assert property ($rose(RESUME_FLAG) |->
    osc_cnt_r == OSC_START_CYCLES + 2 && !SUSPENDED) else $error("resume flag timing wrong");
  wake_drive_a: assert property (CE && SUSPENDED && !HOST_RESUME && wake_src |=>
    RESUME_DRIVE && !SUSPENDED ##1 OSC_ENABLE) else $error("local wake not driven upstream");
  wake_refused_a: assert property (CE && SUSPENDED && !HOST_RESUME && !wake_src |=>
    SUSPENDED && !RESUME_DRIVE && !OSC_ENABLE) else $error("suspend left without a cause");
  remote_flag_a: assert property ($rose(REMOTE_WAKEUP_FLAG) |-> $rose(RESUME_FLAG) && IRQ)
    else $error("remote flag without resume flag");
  resume_hold_a: assert property (RESUME_FLAG && !(CE && CLR_RESUME) |=> RESUME_FLAG)
    else $error("resume flag dropped uncleared");
  remote_hold_a: assert property (REMOTE_WAKEUP_FLAG && !(CE && CLR_REMOTE_WAKEUP) |=>
    REMOTE_WAKEUP_FLAG) else $error("remote flag dropped uncleared");
  drive_len_a: assert property ($fell(RESUME_DRIVE) |->
    drv_cnt_r == RESUME_DRIVE_CYCLES + 2) else $error("upstream resume length wrong");
  cover property ($fell(OSC_ENABLE));
  cover property (CE && SUSPENDED && HOST_RESUME);
  cover property ($rose(REMOTE_WAKEUP_FLAG));
endmodule
bind usr_suspend_resume usr_sr_assertions #(.OSC_START_CYCLES(OSC_START_CYCLES),
  .RESUME_DRIVE_CYCLES(RESUME_DRIVE_CYCLES)) chk_u (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
  .SLEEP_ENABLE(SLEEP_ENABLE), .SLEEP_MODE(SLEEP_MODE), .SLEEP_EXEC(SLEEP_EXEC),
  .PIN_WAKE_EN(PIN_WAKE_EN), .HOST_RESUME(HOST_RESUME), .EXT_IRQ0(EXT_IRQ0),
  .EXT_IRQ1(EXT_IRQ1), .WAKE_PIN_N(WAKE_PIN_N), .CLR_RESUME(CLR_RESUME),
  .CLR_REMOTE_WAKEUP(CLR_REMOTE_WAKEUP), .OSC_ENABLE(OSC_ENABLE), .RESUME_DRIVE(RESUME_DRIVE),
  .SUSPENDED(SUSPENDED), .RESUME_FLAG(RESUME_FLAG), .REMOTE_WAKEUP_FLAG(REMOTE_WAKEUP_FLAG),
  .IRQ(IRQ));

//--- usr_suspend_resume.sv
`timescale 1ns/10ps
module usr_suspend_resume #(
  parameter int unsigned OSC_START_CYCLES    = usr_pkg::OSC_START_CYC,
  parameter int unsigned RESUME_DRIVE_CYCLES = usr_pkg::RESUME_DRIVE_CYC
) (
  input  wire logic REF_CLK,             // 40 MHz always-on clock
  input  wire logic RST,                 // synchronous reset, active high
  input  wire logic CE,                  // clock enable, freezes state when low
  input  wire logic SLEEP_ENABLE,        // sleep-enable bit of mcu_control_reg
  input  wire logic SLEEP_MODE,          // sleep-mode bit of mcu_control_reg
  input  wire logic SLEEP_EXEC,          // pulse: sleep instruction executed
  input  wire logic PIN_WAKE_EN,         // bit 2 of overcurrent_detect_reg
  input  wire logic SUSPEND_DETECT,      // pulse: bus suspend seen
  input  wire logic HOST_RESUME,         // host resume signaling on the bus
  input  wire logic EXT_IRQ0,            // external interrupt 0, active high
  input  wire logic EXT_IRQ1,            // external interrupt 1, active high
  input  wire logic WAKE_PIN_N,          // wake_pin, pulled up, active low
  input  wire logic CLR_GLOBAL_SUSPEND,  // pulse: firmware clears suspend flag
  input  wire logic CLR_RESUME,          // pulse: firmware clears resume flag
  input  wire logic CLR_REMOTE_WAKEUP,   // pulse: firmware clears remote flag
  output logic      OSC_ENABLE,          // oscillator / pll run enable
  output logic      RESUME_DRIVE,        // drive resume signaling upstream
  output logic      SUSPENDED,           // sequencer is in suspend
  output logic      GLOBAL_SUSPEND_FLAG, // global_suspend_flag
  output logic      RESUME_FLAG,         // resume_flag
  output logic      REMOTE_WAKEUP_FLAG,  // remote_wakeup_flag
  output logic      IRQ                  // interrupt request, any flag set
);

  // all state of the sequencer
  typedef struct packed {
    usr_pkg::usr_state_t st;         // sequencer state
    logic                remote;     // wake came from a local source
    logic                osc_en;     // oscillator enable
    logic                drive;      // upstream resume drive
    logic                gsusp;      // global suspend flag
    logic                resf;       // resume flag
    logic                rwu;        // remote wake-up flag
    logic                irq;        // registered interrupt request
    logic                susp;       // registered suspended indication
    logic                ld_osc;     // pulse: start oscillator allowance
    logic                ld_drv;     // pulse: start resume drive timer
  } usr_main_t;

  usr_main_t s_r;                    // registered state
  usr_main_t s_nxt;                  // next state

  logic      osc_busy;               // oscillator allowance still running
  logic      osc_done;               // pulse: oscillator assumed stable
  logic      drv_busy;               // resume drive timer running
  logic      drv_done;               // pulse: resume drive time elapsed
  logic      sleep_req;              // qualified sleep request
  logic      local_wake;             // any enabled local wake source

  //////////////////////////////////////////////////////////////////////////////
  // a local wake source is active in this cycle
  function automatic logic wake_any(input logic irq0, input logic irq1,
                                    input logic pin_en, input logic pin_n);
    wake_any = irq0 | irq1 | (pin_en & ~pin_n);
  endfunction

  // sleep takes effect only with both mcu_control_reg bits set
  assign sleep_req  = SLEEP_EXEC & SLEEP_ENABLE & SLEEP_MODE;
  // ext sources are level sensitive: a source held high across sleep entry
  // wakes the device on the very first suspended cycle
  // the pin source counts only while firmware has enabled it
  assign local_wake = wake_any(EXT_IRQ0, EXT_IRQ1, PIN_WAKE_EN, WAKE_PIN_N);

  //////////////////////////////////////////////////////////////////////////////
  // the oscillator gives no ready indication, so a fixed count stands in
  // for its start-up time; a slow crystal needs a larger parameter
  // oscillator start-up allowance: flags wait for a stable clock
  usr_timer #(
    .WIDTH    (usr_pkg::TIMER_W)
  ) u_osc_tmr (
    .clk      (REF_CLK),
    .rst      (RST),
    .ce       (CE),
    .load     (s_r.ld_osc),
    .load_val (usr_pkg::TIMER_W'(OSC_START_CYCLES)),
    .busy     (osc_busy),
    .done     (osc_done)
  );

  // upstream resume drive length
  usr_timer #(
    .WIDTH    (usr_pkg::TIMER_W)
  ) u_drv_tmr (
    .clk      (REF_CLK),
    .rst      (RST),
    .ce       (CE),
    .load     (s_r.ld_drv),
    .load_val (usr_pkg::TIMER_W'(RESUME_DRIVE_CYCLES)),
    .busy     (drv_busy),
    .done     (drv_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencer and flag logic
  always_comb begin
    s_nxt        = s_r;
    s_nxt.ld_osc = 1'b0;
    s_nxt.ld_drv = 1'b0;

    // firmware clears first, so a hardware set in the same cycle wins
    if (CLR_GLOBAL_SUSPEND) begin
      s_nxt.gsusp = 1'b0;
    end
    if (CLR_RESUME) begin
      s_nxt.resf = 1'b0;
    end
    if (CLR_REMOTE_WAKEUP) begin
      s_nxt.rwu = 1'b0;
    end
    // bus suspend raises the global suspend flag
    if (SUSPEND_DETECT) begin
      s_nxt.gsusp = 1'b1;
    end

    // drive ends once its timer runs out, whatever the state
    if (drv_done && !drv_busy) begin
      s_nxt.drive = 1'b0;
    end

    // requests outside their own state are dropped with no indication,
    // so firmware cannot rely on an error report
    case (s_r.st)
      // a sleep without both control bits acts as a plain idle and
      // leaves the oscillator running
      // running; wait for the sleep instruction
      usr_pkg::ST_AWAKE: begin
        if (sleep_req) begin
          s_nxt.osc_en = 1'b0;
          s_nxt.st     = usr_pkg::ST_SUSPEND;
        end
      end
      // oscillator stopped; host resume has priority over local wake,
      // since the bus is already leaving suspend and no drive is needed
      usr_pkg::ST_SUSPEND: begin
        if (HOST_RESUME) begin
          s_nxt.remote = 1'b0;
          s_nxt.osc_en = 1'b1;
          s_nxt.ld_osc = 1'b1;
          s_nxt.st     = usr_pkg::ST_RESTART;
        end else if (local_wake) begin
          s_nxt.remote = 1'b1;
          s_nxt.drive  = 1'b1;
          s_nxt.ld_drv = 1'b1;
          s_nxt.st     = usr_pkg::ST_WAKE_DRV;
        end
      end
      // drive has started; now restart the oscillator
      usr_pkg::ST_WAKE_DRV: begin
        s_nxt.osc_en = 1'b1;
        s_nxt.ld_osc = 1'b1;
        s_nxt.st     = usr_pkg::ST_RESTART;
      end
      // a sleep request during restart is dropped; firmware only runs
      // again once the flags raise the interrupt
      // flags are raised only once the oscillator is stable
      usr_pkg::ST_RESTART: begin
        if (osc_done) begin
          s_nxt.resf = 1'b1;
          if (s_r.remote) begin
            s_nxt.rwu = 1'b1;
          end
          s_nxt.st = usr_pkg::ST_AWAKE;
        end
      end
      default: begin
        s_nxt.osc_en = 1'b1;
        s_nxt.st     = usr_pkg::ST_AWAKE;
      end
    endcase

    // request stays up as long as any flag stands
    s_nxt.irq  = s_nxt.gsusp | s_nxt.resf | s_nxt.rwu;
    s_nxt.susp = (s_nxt.st == usr_pkg::ST_SUSPEND);
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset is not gated by CE, so the sequencer can always be brought
  // back to a known awake state even while frozen
  // state register, frozen while CE is low
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_r        <= '0;
      s_r.st     <= usr_pkg::ST_AWAKE;
      s_r.osc_en <= usr_pkg::OSC_EN_RST;
      s_r.gsusp  <= usr_pkg::FLAG_RST;
      s_r.resf   <= usr_pkg::FLAG_RST;
      s_r.rwu    <= usr_pkg::FLAG_RST;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // IRQ and SUSPENDED are registered copies rather than state decodes,
  // so no output glitches while the state changes
  // outputs straight from the state register
  assign OSC_ENABLE          = s_r.osc_en;
  assign RESUME_DRIVE        = s_r.drive;
  assign SUSPENDED           = s_r.susp;
  assign GLOBAL_SUSPEND_FLAG = s_r.gsusp;
  assign RESUME_FLAG         = s_r.resf;
  assign REMOTE_WAKEUP_FLAG  = s_r.rwu;
  assign IRQ                 = s_r.irq;

endmodule

//--- usr_timer.sv
`timescale 1ns/10ps
// one-shot down counter: a load starts it, done pulses when it runs out
module usr_timer #(
  parameter int unsigned WIDTH = 20
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic                  busy,
  output logic                  done
);

  // all state of the timer
  typedef struct packed {
    logic [WIDTH-1:0] cnt;   // cycles still to run
    logic             done;  // one-cycle expiry pulse
  } usr_tmr_t;

  usr_tmr_t tmr_r;           // registered state
  usr_tmr_t tmr_nxt;         // next state

  //////////////////////////////////////////////////////////////////////////////
  // next state: a load restarts the count even while busy
  always_comb begin
    tmr_nxt      = tmr_r;
    tmr_nxt.done = 1'b0;
    if (load) begin
      tmr_nxt.cnt = load_val;
    end else if (tmr_r.cnt != '0) begin
      // count down; the last step raises done
      tmr_nxt.cnt = tmr_r.cnt - 1'b1;
      if (tmr_r.cnt == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        tmr_nxt.done = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_r <= '0;
    end else if (ce) begin
      tmr_r <= tmr_nxt;
    end
  end

  assign busy = (tmr_r.cnt != '0);
  assign done = tmr_r.done;

endmodule
